// ===== logic/debug_lock_latch.sv
`timescale 1ns/1ps
// How it works
// - Latch holds 32 bits; vote is 1 when 28 or more match key
// - Vote 1 closes all test, programming and debug ports and modes
// - Vote 1 blocks any further write or erase of the latch
// - Vote sampled only at reset; that sample alone decides lockout
// - Lockout needs key loaded, committed to cells, then a reset
// - After a key write, ports stay open until the next reset
// - Key writes accepted only while flash protection level is none
// - Latch contents can always be read back over the SWD port
// - Flash protection cleared only by a full device erase
// - Block erase/program/verify granted only if block security allows
// - SWD pairs with single-pin or parallel trace; JTAG only parallel
// - Single-pin trace output shares the JTAG data-out pin
// - Parallel trace port drives five pins for fast bulk trace
// - Six program-address and two literal-access breakpoints
// - Debug compare logic is cleared by rstn and holds its state while clkEn is low
// - Watchpoints match address, range or value and can trigger trace
module debug_lock_latch
  import debug_lock_pkg::*;
#(
  parameter logic [31:0] LOCK_KEY = KEY_DEFAULT
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  clkEn,
  // Nonvolatile cell array
  input  wire logic [KEY_BITS-1:0]   nvCellData,
  output logic                       nvWrEn,
  output logic [KEY_BITS-1:0]        nvWrData,
  // Key load and commit from the debug port
  input  wire logic                  keyLoad,
  input  wire logic [KEY_BITS-1:0]   keyData,
  input  wire logic                  keyCommit,
  // Flash protection and erase control
  input  wire logic [PROT_W-1:0]     flashProtLevel,
  input  wire logic                  fullEraseReq,
  output logic                       protClear,
  input  wire logic                  blockOpReq,
  input  wire logic                  blockSecOk,
  output logic                       blockOpGrant,
  // Port selection and lock state
  input  wire logic [2:0]            dbgSel,
  input  wire logic                  testModeReq,
  output logic                       lockedOut,
  output logic                       jtagEn,
  output logic                       swdEn,
  output logic                       pinTrcEn,
  output logic                       traceEn,
  output logic                       testModeEn,
  // Shared data-out pin
  input  wire logic                  jtagTdo,
  input  wire logic                  jtagTdoOe,
  input  wire logic                  pinTrcBit,
  output logic                       tdoPinOut,
  output logic                       tdoPinOe,
  // Parallel trace pins
  input  wire logic [TRACE_PINS-1:0] traceWord,
  output logic [TRACE_PINS-1:0]      tracePins,
  // Latch readback over SWD
  input  wire logic                  swdLatchRd,
  output logic                       swdLatchVld,
  output logic [KEY_BITS-1:0]        swdLatchData,
  // Breakpoint configuration and compare
  input  wire logic                  bpWrEn,
  input  wire logic [BP_IDX_W-1:0]   bpSel,
  input  wire logic [31:0]           bpAddrIn,
  input  wire logic                  bpOnIn,
  input  wire logic                  fetchValid,
  input  wire logic [31:0]           fetchAddr,
  input  wire logic                  litValid,
  input  wire logic [31:0]           litAddr,
  output logic                       bpHit,
  output logic [BP_IDX_W-1:0]        bpHitIdx,
  // Watchpoint configuration and compare
  input  wire logic                  wpWrEn,
  input  wire logic [1:0]            wpModeIn,
  input  wire logic [31:0]           wpLoIn,
  input  wire logic [31:0]           wpHiIn,
  input  wire logic [31:0]           wpValIn,
  input  wire logic                  wpTrigIn,
  input  wire logic                  dataValid,
  input  wire logic [31:0]           dataAddr,
  input  wire logic [31:0]           dataVal,
  output logic                       wpHit,
  output logic                       traceTrig
);

  ////////////////////////////////////////////////////////////////////////////
  // Lock vote and capture

  logic latchVote;
  logic captured_r, captured_nxt;
  logic locked_r,   locked_nxt;
  logic portsOpen;

  lock_key_vote #(.LOCK_KEY(LOCK_KEY)) u_vote (
    .cells (nvCellData),
    .match (latchVote)
  );

  // First enabled edge after reset takes the vote, then holds it
  always_comb begin
    captured_nxt = 1'b1;
    locked_nxt   = captured_r ? locked_r : latchVote;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      captured_r <= 1'b0;
      locked_r   <= 1'b0;
    end else if (clkEn) begin
      captured_r <= captured_nxt;
      locked_r   <= locked_nxt;
    end
  end

  // Ports closed before capture and for good once locked
  assign portsOpen = captured_r && !locked_r;
  assign lockedOut = locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // Volatile key stage and cell programming

  logic                keyOk;
  logic [KEY_BITS-1:0] keyStage_r, keyStage_nxt;
  logic                nvWrEn_r,   nvWrEn_nxt;

  // Writes need open ports, no protection and an unset latch
  assign keyOk = portsOpen && (flashProtLevel == PROT_NONE)
                 && !latchVote;

  always_comb begin
    keyStage_nxt = keyStage_r;
    nvWrEn_nxt   = 1'b0;
    if (keyOk && keyLoad) begin
      keyStage_nxt = keyData;
    end
    if (keyOk && keyCommit && !keyLoad) begin
      nvWrEn_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      keyStage_r <= '0;
      nvWrEn_r   <= 1'b0;
    end else if (clkEn) begin
      keyStage_r <= keyStage_nxt;
      nvWrEn_r   <= nvWrEn_nxt;
    end
  end

  assign nvWrEn   = nvWrEn_r;
  assign nvWrData = keyStage_r;

  ////////////////////////////////////////////////////////////////////////////
  // Port enables, shared pin, trace pins, flash grants, readback

  dbg_mode_t           mode;
  logic                jtagEn_r,  jtagEn_nxt;
  logic                swdEn_r,   swdEn_nxt;
  logic                pinTrcEn_r, pinTrcEn_nxt;
  logic                trcEn_r,   trcEn_nxt;
  logic                testEn_r,  testEn_nxt;
  logic                tdoOut_r,  tdoOut_nxt;
  logic                tdoOe_r,   tdoOe_nxt;
  logic [TRACE_PINS-1:0] pins_r,  pins_nxt;
  logic                protClr_r, protClr_nxt;
  logic                blkGnt_r,  blkGnt_nxt;
  logic                rdVld_r,   rdVld_nxt;
  logic [KEY_BITS-1:0] rdData_r,  rdData_nxt;

  assign mode = dbg_mode_t'(dbgSel);

  always_comb begin
    jtagEn_nxt = 1'b0;
    swdEn_nxt  = 1'b0;
    pinTrcEn_nxt = 1'b0;
    trcEn_nxt  = 1'b0;
    // Only the legal debug and trace pairings exist
    unique case (mode)
      MODE_OFF:        ;
      MODE_JTAG:       jtagEn_nxt = 1'b1;
      MODE_SWD:        swdEn_nxt  = 1'b1;
      MODE_PIN_TRC:    pinTrcEn_nxt = 1'b1;
      MODE_TRACE:      trcEn_nxt  = 1'b1;
      MODE_JTAG_TRACE: begin
        jtagEn_nxt = 1'b1;
        trcEn_nxt  = 1'b1;
      end
      MODE_SWD_PIN: begin
        swdEn_nxt    = 1'b1;
        pinTrcEn_nxt = 1'b1;
      end
      MODE_SWD_TRACE: begin
        swdEn_nxt  = 1'b1;
        trcEn_nxt  = 1'b1;
      end
    endcase
    // Lockout overrides every selection
    jtagEn_nxt = jtagEn_nxt && portsOpen;
    swdEn_nxt  = swdEn_nxt  && portsOpen;
    pinTrcEn_nxt = pinTrcEn_nxt && portsOpen;
    trcEn_nxt  = trcEn_nxt  && portsOpen;
    testEn_nxt = testModeReq && portsOpen;
    // Data-out pin carries single-pin trace or JTAG data
    tdoOut_nxt = pinTrcEn_nxt ? pinTrcBit : jtagTdo;
    tdoOe_nxt  = pinTrcEn_nxt || (jtagEn_nxt && jtagTdoOe);
    pins_nxt   = trcEn_nxt ? traceWord : '0;
    // Protection clears only with full erase; block ops need security ok
    protClr_nxt = fullEraseReq && portsOpen;
    blkGnt_nxt  = blockOpReq && blockSecOk && portsOpen;
    // Readback stays available for identifying locked parts
    rdVld_nxt  = swdLatchRd;
    rdData_nxt = swdLatchRd ? nvCellData : rdData_r;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      jtagEn_r  <= 1'b0;
      swdEn_r   <= 1'b0;
      pinTrcEn_r <= 1'b0;
      trcEn_r   <= 1'b0;
      testEn_r  <= 1'b0;
      tdoOut_r  <= 1'b0;
      tdoOe_r   <= 1'b0;
      pins_r    <= '0;
      protClr_r <= 1'b0;
      blkGnt_r  <= 1'b0;
      rdVld_r   <= 1'b0;
      rdData_r  <= '0;
    end else if (clkEn) begin
      jtagEn_r  <= jtagEn_nxt;
      swdEn_r   <= swdEn_nxt;
      pinTrcEn_r <= pinTrcEn_nxt;
      trcEn_r   <= trcEn_nxt;
      testEn_r  <= testEn_nxt;
      tdoOut_r  <= tdoOut_nxt;
      tdoOe_r   <= tdoOe_nxt;
      pins_r    <= pins_nxt;
      protClr_r <= protClr_nxt;
      blkGnt_r  <= blkGnt_nxt;
      rdVld_r   <= rdVld_nxt;
      rdData_r  <= rdData_nxt;
    end
  end

  assign jtagEn       = jtagEn_r;
  assign swdEn        = swdEn_r;
  assign pinTrcEn     = pinTrcEn_r;
  assign traceEn      = trcEn_r;
  assign testModeEn   = testEn_r;
  assign tdoPinOut    = tdoOut_r;
  assign tdoPinOe     = tdoOe_r;
  assign tracePins    = pins_r;
  assign protClear    = protClr_r;
  assign blockOpGrant = blkGnt_r;
  assign swdLatchVld  = rdVld_r;
  assign swdLatchData = rdData_r;

  ////////////////////////////////////////////////////////////////////////////
  // Breakpoints and watchpoint, cleared by rstn and held while clkEn is low

  logic [31:0]         bpAddr_r [BP_CNT];
  logic [31:0]         bpAddr_nxt [BP_CNT];
  logic [BP_CNT-1:0]   bpOn_r,   bpOn_nxt;
  logic                bpHit_r,  bpHit_nxt;
  logic [BP_IDX_W-1:0] bpIdx_r,  bpIdx_nxt;
  wp_mode_t            wpMode_r, wpMode_nxt;
  logic [31:0]         wpLo_r,   wpLo_nxt;
  logic [31:0]         wpHi_r,   wpHi_nxt;
  logic [31:0]         wpVal_r,  wpVal_nxt;
  logic                wpTrg_r,  wpTrg_nxt;
  logic                wpHit_r,  wpHit_nxt;
  logic                trig_r,   trig_nxt;
  logic                wpMatch;

  always_comb begin
    bpAddr_nxt = bpAddr_r;
    bpOn_nxt   = bpOn_r;
    wpMode_nxt = wpMode_r;
    wpLo_nxt   = wpLo_r;
    wpHi_nxt   = wpHi_r;
    wpVal_nxt  = wpVal_r;
    wpTrg_nxt  = wpTrg_r;
    bpHit_nxt  = 1'b0;
    bpIdx_nxt  = bpIdx_r;
    // Configuration only through an open debug port
    if (portsOpen && bpWrEn) begin
      bpAddr_nxt[bpSel] = bpAddrIn;
      bpOn_nxt[bpSel]   = bpOnIn;
    end
    if (portsOpen && wpWrEn) begin
      wpMode_nxt = wp_mode_t'(wpModeIn);
      wpLo_nxt   = wpLoIn;
      wpHi_nxt   = wpHiIn;
      wpVal_nxt  = wpValIn;
      wpTrg_nxt  = wpTrigIn;
    end
    // Six fetch comparators then two literal comparators, lowest wins
    for (int i = BP_CNT - 1; i >= 0; i--) begin
      if (bpOn_r[i] && ((i < BP_PROG_CNT)
          ? (fetchValid && fetchAddr == bpAddr_r[i])
          : (litValid && litAddr == bpAddr_r[i]))) begin
        bpHit_nxt = 1'b1;
        bpIdx_nxt = BP_IDX_W'(i);
      end
    end
    unique case (wpMode_r)
      WP_OFF:   wpMatch = 1'b0;
      WP_ADDR:  wpMatch = dataAddr == wpLo_r;
      WP_RANGE: wpMatch = inWindow(dataAddr, wpLo_r, wpHi_r);
      WP_VALUE: wpMatch = dataVal == wpVal_r;
    endcase
    wpHit_nxt = dataValid && wpMatch;
    trig_nxt  = wpHit_nxt && wpTrg_r;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BP_CNT; i++) begin
        bpAddr_r[i] <= '0;
      end
      bpOn_r   <= '0;
      bpHit_r  <= 1'b0;
      bpIdx_r  <= '0;
      wpMode_r <= WP_OFF;
      wpLo_r   <= '0;
      wpHi_r   <= '0;
      wpVal_r  <= '0;
      wpTrg_r  <= 1'b0;
      wpHit_r  <= 1'b0;
      trig_r   <= 1'b0;
    end else if (clkEn) begin
      bpAddr_r <= bpAddr_nxt;
      bpOn_r   <= bpOn_nxt;
      bpHit_r  <= bpHit_nxt;
      bpIdx_r  <= bpIdx_nxt;
      wpMode_r <= wpMode_nxt;
      wpLo_r   <= wpLo_nxt;
      wpHi_r   <= wpHi_nxt;
      wpVal_r  <= wpVal_nxt;
      wpTrg_r  <= wpTrg_nxt;
      wpHit_r  <= wpHit_nxt;
      trig_r   <= trig_nxt;
    end
  end

  assign bpHit     = bpHit_r;
  assign bpHitIdx  = bpIdx_r;
  assign wpHit     = wpHit_r;
  assign traceTrig = trig_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_vote_count: assert property (latchVote ==
    ($countones(~(nvCellData ^ LOCK_KEY)) >= 28))
    else $error("lock vote disagrees with agreeing bit count");
  a_locked_ports_shut: assert property ($past(locked_r) |->
    !jtagEn_r && !swdEn_r && !pinTrcEn_r && !trcEn_r && !testEn_r)
    else $error("port enabled while locked");
  a_write_unlocked: assert property (nvWrEn_r && $past(clkEn) |->
    $past(!latchVote))
    else $error("latch write issued with latch vote set");
  a_capture_vote: assert property ($rose(captured_r) |->
    locked_r == $past(latchVote))
    else $error("captured lock differs from vote");
  a_open_after_key: assert property (nvWrEn_r && !locked_r |=>
    !locked_r [*4])
    else $error("lockout before reset after key write");
  a_prot_gate: assert property (nvWrEn_r && $past(clkEn) |->
    $past(flashProtLevel) == PROT_NONE)
    else $error("key written under flash protection");
  a_prot_clear_erase: assert property (protClr_r && $past(clkEn) |->
    $past(fullEraseReq))
    else $error("protection cleared without full erase");
  a_block_grant: assert property (blkGnt_r && $past(clkEn) |->
    $past(blockSecOk))
    else $error("block op granted against security");
  a_legal_pairing: assert property (!(jtagEn_r &&
    (pinTrcEn_r || swdEn_r)))
    else $error("illegal debug and trace pairing");
  a_pin_trace_oe: assert property (pinTrcEn_r |-> tdoOe_r)
    else $error("single-pin trace not driving pin");
  a_bp_index: assert property (bpHit_r && $past(clkEn) |->
    ((bpIdx_r < BP_PROG_CNT) ? $past(fetchValid) : $past(litValid)))
    else $error("breakpoint hit from wrong compare source");
  a_lock_held: assert property (captured_r && $past(captured_r) |->
    $stable(locked_r))
    else $error("lockout changed after capture");
  a_trig_from_wp: assert property (trig_r |-> wpHit_r)
    else $error("trace trigger without watchpoint hit");

  c_locked: cover property ($rose(locked_r));
  c_key_commit: cover property (nvWrEn_r);
  c_bp_literal: cover property (bpHit_r && bpIdx_r >= BP_PROG_CNT);
  c_wp_trigger: cover property (trig_r);

endmodule

// ===== logic/debug_lock_pkg.sv
package debug_lock_pkg;

  // Lock key width and super-majority threshold
  localparam int         KEY_BITS    = 32;
  localparam logic [5:0] VOTE_MIN    = 6'h1C;
  // Default key pattern, value is arbitrary
  localparam logic [31:0] KEY_DEFAULT = 32'h5A3C_96E1;

  // Flash protection level coding
  localparam int         PROT_W      = 2;
  localparam logic [1:0] PROT_NONE   = 2'h0;

  // Breakpoint comparators: program first, literal last
  localparam int         BP_PROG_CNT = 6;
  localparam int         BP_LIT_CNT  = 2;
  localparam int         BP_CNT      = BP_PROG_CNT + BP_LIT_CNT;
  localparam int         BP_IDX_W    = 3;

  // Parallel trace port pin count
  localparam int         TRACE_PINS  = 5;

  // Debug and trace pin configurations
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_JTAG,
    MODE_SWD,
    MODE_PIN_TRC,
    MODE_TRACE,
    MODE_JTAG_TRACE,
    MODE_SWD_PIN,
    MODE_SWD_TRACE
  } dbg_mode_t;

  // Data watchpoint compare kinds
  typedef enum logic [1:0] {
    WP_OFF,
    WP_ADDR,
    WP_RANGE,
    WP_VALUE
  } wp_mode_t;

  // Inclusive address window test
  function automatic logic inWindow(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    inWindow = (a >= lo) && (a <= hi);
  endfunction

endpackage

// ===== logic/lock_key_vote.sv
`timescale 1ns/1ps
module lock_key_vote
  import debug_lock_pkg::*;
#(
  parameter logic [31:0] LOCK_KEY = KEY_DEFAULT
) (
  input  wire logic [KEY_BITS-1:0] cells,
  output logic                     match
);

  logic [5:0] agree;

  // Count cells that agree with the key, then vote
  always_comb begin
    agree = 6'h00;
    for (int i = 0; i < KEY_BITS; i++) begin
      agree = agree + {5'h00, ~(cells[i] ^ LOCK_KEY[i])};
    end
    match = (agree >= VOTE_MIN);
  end

endmodule

// ===== verification/debug_lock_latch_bench.sv
`timescale 1ns/1ps
module debug_lock_latch_bench
  import debug_lock_pkg::*;
();
  // Test key, value is arbitrary
  localparam logic [31:0] KEY = 32'hC3A5_0F1E;
  // Expected {jtag, swd, pin trace, port trace} per mode code
  localparam logic [3:0] MODE_TAB [8] = '{4'h0, 4'h8, 4'h4, 4'h2,
                                          4'h1, 4'h9, 4'h6, 4'h5};
  localparam logic [31:0] WP_HIT [3] = '{32'h2000, 32'h2080, 32'h5000};

  logic ref_clk, rstn, clkEn, keyLoad, keyCommit, fullEraseReq;
  logic blockOpReq, blockSecOk, testModeReq, jtagTdo, jtagTdoOe, pinTrcBit;
  logic swdLatchRd, bpWrEn, bpOnIn, fetchValid, litValid, wpWrEn;
  logic wpTrigIn, dataValid, presetEn;
  logic [31:0] keyData, bpAddrIn, fetchAddr, litAddr, wpLoIn, wpHiIn;
  logic [31:0] wpValIn, dataAddr, dataVal, presetVal, nvCellData;
  logic [2:0]  dbgSel, bpSel, bpHitIdx;
  logic [1:0]  flashProtLevel, wpModeIn;
  logic [4:0]  traceWord, tracePins;
  logic nvWrEn, protClear, blockOpGrant, lockedOut, jtagEn, swdEn, pinTrcEn;
  logic traceEn, testModeEn, tdoPinOut, tdoPinOe, swdLatchVld, bpHit;
  logic wpHit, traceTrig;
  logic [31:0] nvWrData, swdLatchData;
  int   errCount, checksDone;

  ////////////////////////////////////////////////////////////////////////
  // Design and cell array
  debug_lock_latch #(.LOCK_KEY(KEY)) DUT (
    .ref_clk, .rstn, .clkEn, .nvCellData, .nvWrEn, .nvWrData, .keyLoad,
    .keyData, .keyCommit, .flashProtLevel, .fullEraseReq, .protClear,
    .blockOpReq, .blockSecOk, .blockOpGrant, .dbgSel, .testModeReq,
    .lockedOut, .jtagEn, .swdEn, .pinTrcEn, .traceEn, .testModeEn, .jtagTdo,
    .jtagTdoOe, .pinTrcBit, .tdoPinOut, .tdoPinOe, .traceWord, .tracePins,
    .swdLatchRd, .swdLatchVld, .swdLatchData, .bpWrEn, .bpSel, .bpAddrIn,
    .bpOnIn, .fetchValid, .fetchAddr, .litValid, .litAddr, .bpHit,
    .bpHitIdx, .wpWrEn, .wpModeIn, .wpLoIn, .wpHiIn, .wpValIn, .wpTrigIn,
    .dataValid, .dataAddr, .dataVal, .wpHit, .traceTrig);

  nv_cell_model CELLS (.ref_clk, .presetEn, .presetVal, .nvWrEn,
                       .nvWrData, .cells(nvCellData));

  // Clock and watchdog
  always #10 ref_clk = ~ref_clk;
  initial begin
    repeat (5000) @(posedge ref_clk);
    errCount++;
    finishTest();
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic doReset();
    rstn = 1'b0;
    cyc(4);
    rstn = 1'b1;
    cyc(2);
  endtask

  task automatic preset(input logic [31:0] v);
    presetEn = 1'b1;
    presetVal = v;
    cyc(1);
    presetEn = 1'b0;
  endtask

  task automatic loadCommit(input logic [31:0] k);
    keyLoad = 1'b1;
    keyData = k;
    cyc(1);
    keyLoad = 1'b0;
    keyCommit = 1'b1;
    cyc(1);
    keyCommit = 1'b0;
  endtask

  task automatic finishTest();
    $display("checks=%0d errors=%0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tVote();
    for (int w = 3; w <= 5; w++) begin
      preset(KEY ^ ((32'h1 << w) - 32'h1));
      doReset();
      chk(lockedOut, w <= 4);
    end
    preset(KEY);
    cyc(2);
    chk(lockedOut, 1'b0);
  endtask

  task automatic tKey();
    preset(~KEY);
    doReset();
    testModeReq = 1'b1;
    for (int i = 0; i < 8; i++) begin
      dbgSel = 3'(i);
      cyc(1);
      chk({jtagEn, swdEn, pinTrcEn, traceEn}, MODE_TAB[i]);
    end
    chk(testModeEn, 1'b1);
    flashProtLevel = 2'h1;
    loadCommit(KEY);
    chk(nvWrEn, 1'b0);
    flashProtLevel = 2'h0;
    loadCommit(KEY);
    chk(nvWrEn, 1'b1);
    chk(nvWrData, KEY);
    cyc(1);
    // Cells now vote 1: a new key is refused before any reset
    loadCommit(~KEY);
    chk(nvWrEn, 1'b0);
    chk(nvWrData, KEY);
    flashProtLevel = 2'h3;
    cyc(2);
    chk(lockedOut, 1'b0);
    chk(swdEn, 1'b1);
    doReset();
    chk(lockedOut, 1'b1);
    chk({jtagEn, swdEn, pinTrcEn, traceEn, testModeEn}, 5'h00);
    fullEraseReq = 1'b1;
    {blockOpReq, blockSecOk} = 2'b11;
    cyc(1);
    {fullEraseReq, blockOpReq, blockSecOk} = 3'b000;
    chk({protClear, blockOpGrant}, 2'b00);
    flashProtLevel = 2'h0;
    loadCommit(~KEY);
    chk(nvWrEn, 1'b0);
    swdLatchRd = 1'b1;
    cyc(1);
    swdLatchRd = 1'b0;
    chk(swdLatchVld, 1'b1);
    chk(swdLatchData, KEY);
    preset(~KEY);
    doReset();
  endtask

  task automatic tFlash();
    // Frozen clock enable holds the request off
    clkEn = 1'b0;
    fullEraseReq = 1'b1;
    cyc(1);
    chk(protClear, 1'b0);
    clkEn = 1'b1;
    cyc(1);
    fullEraseReq = 1'b0;
    chk(protClear, 1'b1);
    cyc(1);
    chk(protClear, 1'b0);
    blockOpReq = 1'b1;
    cyc(1);
    chk(blockOpGrant, 1'b0);
    blockSecOk = 1'b1;
    cyc(1);
    chk(blockOpGrant, 1'b1);
    blockOpReq = 1'b0;
  endtask

  task automatic tTrace();
    dbgSel = 3'h4;
    cyc(2);
    traceWord = 5'h0A;
    cyc(1);
    chk(tracePins, 5'h0A);
    traceWord = 5'h15;
    cyc(1);
    chk(tracePins, 5'h15);
    dbgSel = 3'h6;
    cyc(2);
    {pinTrcBit, jtagTdo} = 2'b10;
    cyc(1);
    chk({tdoPinOut, tdoPinOe}, 2'b11);
    {pinTrcBit, jtagTdo} = 2'b01;
    cyc(1);
    chk(tdoPinOut, 1'b0);
    chk(tracePins, 5'h00);
    // JTAG alone: pin follows JTAG data and its own enable
    dbgSel = 3'h1;
    jtagTdoOe = 1'b1;
    cyc(2);
    chk({tdoPinOut, tdoPinOe}, 2'b11);
    jtagTdoOe = 1'b0;
    cyc(1);
    chk(tdoPinOe, 1'b0);
  endtask

  task automatic tBreak();
    for (int i = 0; i < BP_CNT; i++) begin
      {bpWrEn, bpOnIn, bpSel} = {2'b11, 3'(i)};
      bpAddrIn = 32'h1000 | (32'(i) << 4);
      cyc(1);
      bpWrEn = 1'b0;
      fetchValid = (i < BP_PROG_CNT);
      litValid = (i >= BP_PROG_CNT);
      {fetchAddr, litAddr} = {2{bpAddrIn}};
      cyc(1);
      {fetchValid, litValid} = 2'b00;
      chk({bpHit, bpHitIdx}, {1'b1, 3'(i)});
    end
    fetchValid = 1'b1;
    fetchAddr = 32'h1060;
    cyc(1);
    fetchValid = 1'b0;
    chk(bpHit, 1'b0);
  endtask

  task automatic tWatch();
    for (int m = 1; m <= 3; m++) begin
      {wpWrEn, wpTrigIn, wpModeIn} = {1'b1, m != 3, 2'(m)};
      {wpLoIn, wpHiIn, wpValIn} = {32'h2000, 32'h20FF, 32'hCAFE};
      cyc(1);
      wpWrEn = 1'b0;
      {dataValid, dataAddr, dataVal} = {1'b1, WP_HIT[m-1], 32'hCAFE};
      cyc(1);
      {dataAddr, dataVal} = {32'h2100, 32'h0};
      chk({wpHit, traceTrig}, {1'b1, m != 3});
      cyc(1);
      dataValid = 1'b0;
      chk(wpHit, 1'b0);
    end
  endtask

  // Main sequence
  initial begin
    {ref_clk, rstn, keyLoad, keyCommit, fullEraseReq} = '0;
    {blockOpReq, blockSecOk, testModeReq, jtagTdo, jtagTdoOe} = '0;
    {pinTrcBit, swdLatchRd, bpWrEn, bpOnIn, fetchValid, litValid} = '0;
    {wpWrEn, wpTrigIn, dataValid, dbgSel, bpSel, traceWord} = '0;
    {keyData, bpAddrIn, fetchAddr, litAddr, wpLoIn, wpHiIn} = '0;
    {wpValIn, dataAddr, dataVal} = '0;
    {flashProtLevel, wpModeIn, errCount, checksDone} = '0;
    clkEn = 1'b1;
    // Cells hold a known non-key value before the first capture
    {presetEn, presetVal} = {1'b1, ~KEY};
    doReset();
    tVote();
    tKey();
    tFlash();
    tTrace();
    tBreak();
    tWatch();
    finishTest();
  end
endmodule

// ===== verification/nv_cell_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Nonvolatile cell array beside the lock latch
module nv_cell_model
  import debug_lock_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                presetEn,
  input  wire logic [KEY_BITS-1:0] presetVal,
  input  wire logic                nvWrEn,
  input  wire logic [KEY_BITS-1:0] nvWrData,
  output logic [KEY_BITS-1:0]      cells
);
  logic [KEY_BITS-1:0] cells_r;
  logic [KEY_BITS-1:0] cells_nxt;

  // Wafer-state preset or program pulse
  always_comb begin
    cells_nxt = cells_r;
    if (presetEn) begin
      cells_nxt = presetVal;
    end else if (nvWrEn) begin
      cells_nxt = nvWrData;
    end
  end

  // No reset here: contents survive a device reset
  always_ff @(posedge ref_clk) begin
    cells_r <= cells_nxt;
  end

  assign cells = cells_r;
endmodule
